/* File: design/dlam_pkg.sv */
package dlam_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int HOLD_MS = 150;
    localparam int HOLD_CYC = (HOLD_MS * (CLK_HZ / 1000));
    localparam int ZERO_LIM_SHORT = 16;
    localparam int ZERO_LIM_LONG = 80;
    localparam int DENS_WIN = 8;
    localparam int DENS_MIN = 1;
    localparam int PULSE_GAP_CYC = 32;
    localparam int TEST_PULSE_CYC = 16;
    localparam int TEST_LEN_CYC = 64;
    localparam int HIST_DEPTH = 96;
    localparam int CNT_W = 16;
    localparam int INTERVAL_MIN = 15;
    localparam int INTERVAL_CYC_HI = 90_000;

    typedef enum logic [1:0] {
        DLAM_ST_RESET = 2'b00,
        DLAM_ST_TEST = 2'b01,
        DLAM_ST_RUN = 2'b10,
        DLAM_ST_FAIL = 2'b11
    } dlam_state_t;

    function automatic logic [31:0] dlam_hold_next(input logic ev, input logic [31:0] cnt,
                                                    input logic [31:0] reload);
        if (ev) begin
            dlam_hold_next = reload;
        end else if (cnt != 32'h0000_0000) begin
            dlam_hold_next = cnt - 32'h0000_0001;
        end else begin
            dlam_hold_next = 32'h0000_0000;
        end
    endfunction
endpackage

/* File: design/dlam_hist_mem.sv */
module dlam_hist_mem
    import dlam_pkg::*;
#(
    parameter int DEPTH = HIST_DEPTH,
    parameter int WIDTH = 4 * CNT_W,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data_q
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end
endmodule

/* File: design/dlam_top.sv */
module dlam_top
    import dlam_pkg::*;
#(
    parameter int HOLD = HOLD_CYC,
    parameter int INTERVAL = INTERVAL_CYC_HI,
    parameter int DEPTH = HIST_DEPTH
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cust_bit_valid,
    input wire logic cust_bit,
    input wire logic cust_ami_sel,
    input wire logic zero_limit_long_sel,
    input wire logic cust_oof,
    input wire logic cust_los,
    input wire logic unframed_ones_sel,
    input wire logic net_pulse,
    input wire logic net_oof,
    input wire logic net_los,
    input wire logic net_bpv_excess,
    input wire logic net_err_sec,
    input wire logic net_sev_err_sec,
    input wire logic net_burst_err_sec,
    input wire logic net_fail_sec,
    input wire logic sec_tick,
    input wire logic loop_code_rx,
    input wire logic dc_loop_req,
    input wire logic dl_loop_msg_rx,
    input wire logic dl_unloop_msg_rx,
    input wire logic port_dl_loop_req,
    input wire logic port_dl_unloop_req,
    input wire logic port_far_loop_req,
    input wire logic selftest_fault,
    input wire logic customer_loopback_control,
    input wire logic [$clog2(DEPTH)-1:0] perf_rd_addr,
    output logic [4*CNT_W-1:0] perf_rd_data,
    output logic zero_run_alarm,
    output logic low_density_alarm,
    output logic cust_frame_loss,
    output logic net_frame_loss,
    output logic bipolar_violation_alarm,
    output logic carrier_group_alarm,
    output logic pulses_present,
    output logic line_loopback_active,
    output logic datalink_loopback_active,
    output logic far_loop_cmd_send,
    output logic unit_failure_indicator,
    output logic cust_return_bit,
    output logic cust_return_valid,
    output logic net_ones_send,
    output logic net_ones_framed
);
    localparam int AW = $clog2(DEPTH);

    dlam_state_t st_q, st_d;
    logic [7:0] test_cnt_q;
    logic [6:0] zrun_q;
    logic [DENS_WIN-1:0] dwin_q;
    logic [5:0] gap_q;
    logic [31:0] h_zero_q, h_dens_q, h_coof_q, h_noof_q, h_bpv_q;
    logic dlb_q, far_q, ret_bit_q, ret_val_q;
    logic [CNT_W-1:0] es_q, ses_q, bes_q, fs_q;
    logic [31:0] ivl_q;
    logic [AW-1:0] wptr_q;

    wire run = (st_q == DLAM_ST_RUN) || (st_q == DLAM_ST_FAIL);
    wire cust_zero = cust_bit_valid && !cust_bit;
    wire [6:0] zero_lim = zero_limit_long_sel ? 7'(ZERO_LIM_LONG) : 7'(ZERO_LIM_SHORT);
    wire zero_ev = run && cust_ami_sel && cust_zero && (zrun_q + 7'h01 >= zero_lim);
    wire [DENS_WIN-1:0] dwin_d = {dwin_q[DENS_WIN-2:0], cust_bit};
    wire dens_ev = run && cust_ami_sel && cust_bit_valid
        && ($countones(dwin_d) < DENS_MIN);
    wire ivl_end = (ivl_q == 32'(INTERVAL - 1));
    wire [31:0] hold_r = 32'(HOLD);

    // Self-test sequence and failure lamp
    always_comb begin
        st_d = st_q;
        case (st_q)
            DLAM_ST_RESET: st_d = DLAM_ST_TEST;
            DLAM_ST_TEST: begin
                if (test_cnt_q == 8'(TEST_LEN_CYC - 1)) begin
                    st_d = selftest_fault ? DLAM_ST_FAIL : DLAM_ST_RUN;
                end
            end
            DLAM_ST_RUN: st_d = DLAM_ST_RUN;
            DLAM_ST_FAIL: st_d = DLAM_ST_FAIL;
            default: st_d = DLAM_ST_RESET;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q <= DLAM_ST_RESET;
            test_cnt_q <= 8'h00;
        end else begin
            st_q <= st_d;
            test_cnt_q <= (st_q == DLAM_ST_TEST) ? test_cnt_q + 8'h01 : 8'h00;
        end
    end

    assign unit_failure_indicator = (st_q == DLAM_ST_FAIL)
        || ((st_q == DLAM_ST_TEST) && (test_cnt_q < 8'(TEST_PULSE_CYC)));

    // Customer-side monitors
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            zrun_q <= 7'h00;
            dwin_q <= '1;
        end else if (cust_bit_valid) begin
            zrun_q <= cust_bit ? 7'h00 : (zero_ev ? 7'h00 : zrun_q + 7'h01);
            dwin_q <= dwin_d;
        end
    end

    // Retriggerable hold timers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            h_zero_q <= 32'h0000_0000;
            h_dens_q <= 32'h0000_0000;
            h_coof_q <= 32'h0000_0000;
            h_noof_q <= 32'h0000_0000;
            h_bpv_q <= 32'h0000_0000;
        end else begin
            h_zero_q <= dlam_hold_next(zero_ev, h_zero_q, hold_r);
            h_dens_q <= dlam_hold_next(dens_ev, h_dens_q, hold_r);
            h_coof_q <= dlam_hold_next(run && cust_oof, h_coof_q, hold_r);
            h_noof_q <= dlam_hold_next(run && net_oof, h_noof_q, hold_r);
            h_bpv_q <= dlam_hold_next(run && net_bpv_excess, h_bpv_q, hold_r);
        end
    end

    assign zero_run_alarm = h_zero_q != 32'h0000_0000;
    assign low_density_alarm = h_dens_q != 32'h0000_0000;
    assign cust_frame_loss = h_coof_q != 32'h0000_0000;
    assign net_frame_loss = h_noof_q != 32'h0000_0000;
    assign bipolar_violation_alarm = h_bpv_q != 32'h0000_0000;
    assign carrier_group_alarm = run && (net_oof || net_los);
    assign pulses_present = run && (gap_q != 6'h00);

    // Network pulse presence and loopbacks
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gap_q <= 6'h00;
            dlb_q <= 1'b0;
            far_q <= 1'b0;
        end else begin
            gap_q <= net_pulse ? 6'(PULSE_GAP_CYC) : (gap_q != 6'h00 ? gap_q - 6'h01 : 6'h00);
            if (run && (dl_loop_msg_rx || port_dl_loop_req)) begin
                dlb_q <= 1'b1;
            end else if (dl_unloop_msg_rx || port_dl_unloop_req) begin
                dlb_q <= 1'b0;
            end
            far_q <= run && port_far_loop_req;
        end
    end

    assign line_loopback_active = run && (loop_code_rx || dc_loop_req);
    assign datalink_loopback_active = dlb_q;
    assign far_loop_cmd_send = far_q;

    // Customer loopback and keep-alive ones
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ret_bit_q <= 1'b0;
            ret_val_q <= 1'b0;
        end else begin
            ret_bit_q <= cust_bit;
            ret_val_q <= customer_loopback_control && cust_bit_valid;
        end
    end

    assign cust_return_bit = ret_bit_q;
    assign cust_return_valid = ret_val_q;
    assign net_ones_send = run && cust_los;
    assign net_ones_framed = run && cust_los && !unframed_ones_sel;

    // Performance counters and interval history
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            es_q <= '0;
            ses_q <= '0;
            bes_q <= '0;
            fs_q <= '0;
            ivl_q <= 32'h0000_0000;
            wptr_q <= '0;
        end else begin
            ivl_q <= ivl_end ? 32'h0000_0000 : ivl_q + 32'h0000_0001;
            if (ivl_end) begin
                es_q <= CNT_W'(sec_tick && net_err_sec);
                ses_q <= CNT_W'(sec_tick && net_sev_err_sec);
                bes_q <= CNT_W'(sec_tick && net_burst_err_sec);
                fs_q <= CNT_W'(sec_tick && net_fail_sec);
                wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + AW'(1);
            end else if (sec_tick) begin
                es_q <= es_q + CNT_W'(net_err_sec);
                ses_q <= ses_q + CNT_W'(net_sev_err_sec);
                bes_q <= bes_q + CNT_W'(net_burst_err_sec);
                fs_q <= fs_q + CNT_W'(net_fail_sec);
            end
        end
    end

    dlam_hist_mem #(.DEPTH(DEPTH), .WIDTH(4 * CNT_W), .AW(AW)) u_hist (
        .mclk(mclk),
        .wr_en(ivl_end),
        .wr_addr(wptr_q),
        .wr_data({es_q, ses_q, bes_q, fs_q}),
        .rd_addr(perf_rd_addr),
        .rd_data_q(perf_rd_data)
    );

    sequence s_bpv_ev;
        run && net_bpv_excess;
    endsequence

    a_fail_steady: assert property (@(posedge mclk) disable iff (!nrst)
        ((st_q == DLAM_ST_TEST) && (test_cnt_q == 8'(TEST_LEN_CYC - 1)) && selftest_fault)
            |=> unit_failure_indicator [*8])
        else $error("failure lamp not steady");
    a_test_blink: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(st_q == DLAM_ST_TEST) |-> unit_failure_indicator)
        else $error("no blink in self-test");
    a_zero_flag: assert property (@(posedge mclk) disable iff (!nrst)
        zero_ev |=> zero_run_alarm)
        else $error("zero alarm missing");
    a_dens_ami: assert property (@(posedge mclk) disable iff (!nrst)
        (!cust_ami_sel && !low_density_alarm) |=> !low_density_alarm)
        else $error("density check outside AMI");
    a_coof_hold: assert property (@(posedge mclk) disable iff (!nrst)
        (run && cust_oof) |=> cust_frame_loss [*8])
        else $error("customer frame loss not held");
    a_noof_hold: assert property (@(posedge mclk) disable iff (!nrst)
        (run && net_oof) |=> net_frame_loss [*8])
        else $error("network frame loss not held");
    a_bpv_hold: assert property (@(posedge mclk) disable iff (!nrst)
        s_bpv_ev |=> (h_bpv_q == hold_r) ##1 bipolar_violation_alarm)
        else $error("violation hold not restarted");
    a_cga_cause: assert property (@(posedge mclk) disable iff (!nrst)
        carrier_group_alarm |-> (net_oof || net_los))
        else $error("carrier alarm without cause");
    a_pulse_track: assert property (@(posedge mclk) disable iff (!nrst)
        (run && net_pulse) |=> pulses_present)
        else $error("pulse indicator missing");
    a_llb_src: assert property (@(posedge mclk) disable iff (!nrst)
        line_loopback_active |-> (loop_code_rx || dc_loop_req))
        else $error("line loopback without request");
    a_dlb_set: assert property (@(posedge mclk) disable iff (!nrst)
        (run && port_dl_loop_req) |=> datalink_loopback_active)
        else $error("datalink loopback not entered");
    a_far_send: assert property (@(posedge mclk) disable iff (!nrst)
        (run && port_far_loop_req) |=> far_loop_cmd_send)
        else $error("far loop command not sent");
    a_cust_loop: assert property (@(posedge mclk) disable iff (!nrst)
        (customer_loopback_control && cust_bit_valid) |=>
            (cust_return_valid && cust_return_bit == $past(cust_bit)))
        else $error("customer data not returned");
    a_ones_mode: assert property (@(posedge mclk) disable iff (!nrst)
        net_ones_framed |-> (net_ones_send && !unframed_ones_sel))
        else $error("ones framing wrong");
endmodule

/* File: tb/dlam_line_model.sv */
module dlam_line_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cust_en,
    input wire logic zeros_mode,
    input wire logic net_en,
    output logic cust_bit_valid,
    output logic cust_bit,
    output logic net_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lf_q;
    logic [1:0] ph_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lf_q <= 8'h38;
            ph_q <= 2'h0;
            cust_bit_valid <= 1'b0;
            cust_bit <= 1'b0;
            net_pulse <= 1'b0;
        end else begin
            ph_q <= ph_q + 2'h1;
            lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5] ^ lf_q[4] ^ lf_q[3]};
            cust_bit_valid <= cust_en & ph_q[0];
            // Idle cycles toggle so no stale bit is seen
            cust_bit <= (cust_en & ph_q[0]) ? (~zeros_mode & lf_q[0]) : ~cust_bit;
            net_pulse <= net_en & (ph_q == 2'h3);
        end
    end
endmodule

/* File: tb/tb_dlam_top.sv */
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb_dlam_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dlam_pkg::*;
    localparam int HOLD = 20;
    logic mclk, nrst, cust_bit_valid, cust_bit, net_pulse, cust_en, zeros_mode, net_en;
    logic cust_ami_sel, zero_limit_long_sel, cust_los, unframed_ones_sel, net_los;
    logic net_err_sec, net_sev_err_sec, net_burst_err_sec, net_fail_sec, sec_tick;
    logic loop_code_rx, dc_loop_req, port_far_loop_req, selftest_fault;
    logic customer_loopback_control, cust_oof, net_oof, net_bpv_excess;
    logic dl_loop_msg_rx, dl_unloop_msg_rx, port_dl_loop_req, port_dl_unloop_req;
    logic [6:0] perf_rd_addr;
    logic [63:0] perf_rd_data;
    logic zero_run_alarm, low_density_alarm, cust_frame_loss, net_frame_loss;
    logic bipolar_violation_alarm, carrier_group_alarm, pulses_present, line_loopback_active;
    logic datalink_loopback_active, far_loop_cmd_send, unit_failure_indicator;
    logic cust_return_bit, cust_return_valid, net_ones_send, net_ones_framed;
    logic [2:0] ev, alm;
    logic [3:0] dlv;
    logic [7:0] rnd_q;
    logic pv, pb, lb_q, lchk;
    int zcnt, cyc, error_cnt, samples_checked;
    localparam int IVL = 50;
    logic [63:0] hm [96];
    bit hv [96];
    logic [63:0] pc, exp_q, inc;
    logic ok_q;
    int ivl, wp;
    assign {net_bpv_excess, net_oof, cust_oof} = ev;
    assign alm = {bipolar_violation_alarm, net_frame_loss, cust_frame_loss};
    assign {port_dl_unloop_req, port_dl_loop_req, dl_unloop_msg_rx, dl_loop_msg_rx} = dlv;
    assign inc = {15'h0, net_err_sec, 15'h0, net_sev_err_sec, 15'h0, net_burst_err_sec,
        15'h0, net_fail_sec};
    dlam_top #(.HOLD(HOLD), .INTERVAL(IVL)) DUT (
        .mclk(mclk), .nrst(nrst), .cust_bit_valid(cust_bit_valid), .cust_bit(cust_bit),
        .cust_ami_sel(cust_ami_sel), .zero_limit_long_sel(zero_limit_long_sel),
        .cust_oof(cust_oof), .cust_los(cust_los), .unframed_ones_sel(unframed_ones_sel),
        .net_pulse(net_pulse), .net_oof(net_oof), .net_los(net_los),
        .net_bpv_excess(net_bpv_excess), .net_err_sec(net_err_sec),
        .net_sev_err_sec(net_sev_err_sec), .net_burst_err_sec(net_burst_err_sec),
        .net_fail_sec(net_fail_sec), .sec_tick(sec_tick), .loop_code_rx(loop_code_rx),
        .dc_loop_req(dc_loop_req), .dl_loop_msg_rx(dl_loop_msg_rx),
        .dl_unloop_msg_rx(dl_unloop_msg_rx), .port_dl_loop_req(port_dl_loop_req),
        .port_dl_unloop_req(port_dl_unloop_req), .port_far_loop_req(port_far_loop_req),
        .selftest_fault(selftest_fault),
        .customer_loopback_control(customer_loopback_control),
        .perf_rd_addr(perf_rd_addr), .perf_rd_data(perf_rd_data),
        .zero_run_alarm(zero_run_alarm), .low_density_alarm(low_density_alarm),
        .cust_frame_loss(cust_frame_loss), .net_frame_loss(net_frame_loss),
        .bipolar_violation_alarm(bipolar_violation_alarm),
        .carrier_group_alarm(carrier_group_alarm), .pulses_present(pulses_present),
        .line_loopback_active(line_loopback_active),
        .datalink_loopback_active(datalink_loopback_active),
        .far_loop_cmd_send(far_loop_cmd_send), .unit_failure_indicator(unit_failure_indicator),
        .cust_return_bit(cust_return_bit), .cust_return_valid(cust_return_valid),
        .net_ones_send(net_ones_send), .net_ones_framed(net_ones_framed)
    );
    dlam_line_model LM (
        .mclk(mclk), .nrst(nrst), .cust_en(cust_en), .zeros_mode(zeros_mode),
        .net_en(net_en), .cust_bit_valid(cust_bit_valid), .cust_bit(cust_bit),
        .net_pulse(net_pulse)
    );
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic int zlim(input logic l);
        return l ? ZERO_LIM_LONG : ZERO_LIM_SHORT;
    endfunction
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic pulse_ev(input logic [2:0] v);
        @(posedge mclk) ev <= v;
        @(posedge mclk) ev <= 3'h0;
        @(negedge mclk);
    endtask
    task automatic pulse_dl(input logic [3:0] v);
        @(posedge mclk) dlv <= v;
        @(posedge mclk) dlv <= 4'h0;
        @(negedge mclk);
    endtask
    task automatic wait_z(input int n);
        for (int t = 0; t < 400 && zcnt != n; t++) @(negedge mclk);
    endtask
    task automatic do_reset(input logic f);
        @(posedge mclk) nrst <= 1'b0;
        selftest_fault <= f;
        repeat (15) @(negedge mclk);
        `CHK("rst_clear", 7'h00, {alm, zero_run_alarm, low_density_alarm, far_loop_cmd_send, datalink_loopback_active})
        @(posedge mclk) nrst <= 1'b1;
        repeat (3) @(negedge mclk);
        `CHK("test_blink_on", 1'b1, unit_failure_indicator)
        repeat (17) @(negedge mclk);
        `CHK("test_blink_off", 1'b0, unit_failure_indicator)
        pulse_ev(3'h2);
        `CHK("test_ignore", 1'b0, net_frame_loss)
        repeat (60) @(negedge mclk);
        `CHK("fail_lamp", f, unit_failure_indicator)
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        rnd_q <= lfsr_next(rnd_q);
        {net_err_sec, net_sev_err_sec, net_burst_err_sec, net_fail_sec} <= rnd_q[3:0];
        sec_tick <= rnd_q[7] & rnd_q[6];
        perf_rd_addr <= {3'h0, rnd_q[5:2]};
        pv <= cust_bit_valid;
        pb <= cust_bit;
        lb_q <= customer_loopback_control;
        zcnt <= !cust_bit_valid ? zcnt : cust_bit ? 0 : zcnt + 1;
        if (lchk && lb_q) begin
            `CHK("ret_valid", pv, cust_return_valid)
            if (pv) `CHK("ret_bit", pb, cust_return_bit)
        end
        if (ok_q) `CHK("perf", exp_q, perf_rd_data)
        ok_q <= hv[perf_rd_addr];
        exp_q <= hm[perf_rd_addr];
        // Interval history model, one word per closed interval
        if (!nrst) begin
            {ivl, wp, pc} = '0;
        end else if (ivl == IVL - 1) begin
            hm[wp] = pc;
            hv[wp] = 1'b1;
            wp = (wp == 95) ? 0 : wp + 1;
            ivl = 0;
            pc = sec_tick ? inc : 64'h0;
        end else begin
            ivl++;
            if (sec_tick) pc = pc + inc;
        end
        if (cyc > 5000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        {nrst, cust_en, zeros_mode, net_en, cust_ami_sel, zero_limit_long_sel} = '0;
        {cust_los, unframed_ones_sel, net_los, loop_code_rx, dc_loop_req} = '0;
        {port_far_loop_req, selftest_fault, customer_loopback_control, lchk} = '0;
        {net_err_sec, net_sev_err_sec, net_burst_err_sec, net_fail_sec, sec_tick} = '0;
        {ev, dlv, perf_rd_addr, pv, pb, lb_q, ok_q} = '0;
        {zcnt, cyc, error_cnt, samples_checked} = '0;
        rnd_q = 8'h38;
        do_reset(1'b0);
        cust_en <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            pulse_ev(3'h1 << i);
            `CHK("hold_set", 1'b1, alm[i])
            repeat (4) @(negedge mclk);
            pulse_ev(3'h1 << i);
            repeat (HOLD - 4) @(negedge mclk);
            `CHK("hold_retrig", 1'b1, alm[i])
            repeat (6) @(negedge mclk);
            `CHK("hold_end", 1'b0, alm[i])
        end
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk) {net_los, loop_code_rx, cust_los} <= {3{k[1]}};
            {dc_loop_req, unframed_ones_sel} <= {2{k[0]}};
            ev <= {1'b0, k[0], 1'b0};
            @(negedge mclk);
            `CHK("cga", k != 0, carrier_group_alarm)
            `CHK("llb", k != 0, line_loopback_active)
            `CHK("ones", k[1], net_ones_send)
            if (k[1]) `CHK("ones_frm", !k[0], net_ones_framed)
        end
        @(posedge mclk) {net_los, loop_code_rx, cust_los, dc_loop_req, ev} <= '0;
        net_en <= 1'b1;
        repeat (10) @(negedge mclk);
        `CHK("pulses_on", 1'b1, pulses_present)
        @(posedge mclk) net_en <= 1'b0;
        repeat (20) @(negedge mclk);
        `CHK("pulses_gap", 1'b1, pulses_present)
        repeat (20) @(negedge mclk);
        `CHK("pulses_off", 1'b0, pulses_present)
        for (int i = 0; i < 2; i++) begin
            pulse_dl(4'h1 << (2 * i));
            `CHK("dlb_set", 1'b1, datalink_loopback_active)
            pulse_dl(4'h3 << (2 * i));
            `CHK("dlb_both", 1'b1, datalink_loopback_active)
            pulse_dl(4'h2 << (2 * i));
            `CHK("dlb_clr", 1'b0, datalink_loopback_active)
        end
        @(posedge mclk) port_far_loop_req <= 1'b1;
        @(posedge mclk) port_far_loop_req <= 1'b0;
        @(negedge mclk);
        `CHK("far_cmd", 1'b1, far_loop_cmd_send)
        @(negedge mclk);
        `CHK("far_cmd_end", 1'b0, far_loop_cmd_send)
        @(posedge mclk) customer_loopback_control <= 1'b1;
        lchk <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            @(posedge mclk) cust_ami_sel <= (c < 2);
            zero_limit_long_sel <= (c > 0);
            zeros_mode <= 1'b0;
            repeat (40) @(negedge mclk);
            @(posedge mclk) zeros_mode <= 1'b1;
            wait_z(zlim(c > 0) - 1);
            `CHK("zero_early", 1'b0, zero_run_alarm)
            wait_z(zlim(c > 0));
            repeat (3) @(negedge mclk);
            `CHK("zero_run", c < 2, zero_run_alarm)
            `CHK("low_dens", c < 2, low_density_alarm)
        end
        @(posedge mclk) {zeros_mode, lchk, customer_loopback_control} <= '0;
        pulse_dl(4'h1);
        pulse_ev(3'h7);
        do_reset(1'b1);
        repeat (30) @(negedge mclk);
        `CHK("fail_steady", 1'b1, unit_failure_indicator)
        test_done();
    end
endmodule
